// ==== design/sda_consts.svh ====
// constants for the descriptor-format sense assembler
// assumes byte offsets count from byte 0 of the sense buffer
`ifndef SDA_CONSTS_SVH
`define SDA_CONSTS_SVH

// span of the buffer built here
`define SDA_BUF_FIRST 6'h14
`define SDA_BUF_LAST 6'h3b
`define SDA_IMG_BYTES 40
`define SDA_DESC_MAX 3'h7
`define SDA_DESC_HERE 3'h6

// descriptor start offsets in the sense buffer
`define SDA_CS_OFS 6'h14
`define SDA_SKS_OFS 6'h20
`define SDA_FRU_OFS 6'h28
`define SDA_BLK_OFS 6'h2c
`define SDA_UEC_OFS 6'h30
`define SDA_PER_OFS 6'h34

// descriptor end offsets in the sense buffer
`define SDA_CS_END 6'h1f
`define SDA_SKS_END 6'h27
`define SDA_FRU_END 6'h2b
`define SDA_BLK_END 6'h2f
`define SDA_UEC_END 6'h33
`define SDA_PER_END 6'h3b

// type codes and additional lengths
`define SDA_CS_TYPE 8'h01
`define SDA_CS_LEN 8'h0a
`define SDA_SKS_TYPE 8'h02
`define SDA_SKS_LEN 8'h06
`define SDA_FRU_TYPE 8'h03
`define SDA_FRU_LEN 8'h02
`define SDA_BLK_TYPE 8'h05
`define SDA_BLK_LEN 8'h02
`define SDA_UEC_TYPE 8'h80
`define SDA_UEC_LEN 8'h02
`define SDA_PER_TYPE 8'h81
`define SDA_PER_LEN 8'h06

// incorrect-length bit position in block command byte 3
`define SDA_ILI_BIT 5

// reset values
`define SDA_BYTE_RST 8'h00
`define SDA_OFS_RST 6'h00
`define SDA_CNT_RST 3'h0

`endif

// ==== design/sda_pkg.sv ====
// types shared by the sense descriptor assembler files
// assumes sda_consts.svh is on the include path
package sda_pkg;

  typedef logic [7:0] sda_byte_t;
  typedef logic [5:0] sda_ofs_t;

  // stream state
  typedef enum logic {
    sda_st_idle,
    sda_st_send
  } sda_state_t;

  // which descriptor a buffer byte belongs to
  typedef enum logic [2:0] {
    sda_desc_cmd,
    sda_desc_sks,
    sda_desc_fru,
    sda_desc_blk,
    sda_desc_uec,
    sda_desc_per
  } sda_desc_t;

endpackage : sda_pkg

// ==== design/sda_info_select.sv ====
// information field selector for the information descriptor
// assumes residue and address come from same-clock logic
`timescale 1ns/1ps

module sda_info_select #(
  parameter int RES_W = 32
) (
  input wire logic ili,                     // incorrect-length bit
  input wire logic [63:0] lba,              // block address
  input wire logic [RES_W-1:0] residue,     // signed length residue
  output logic [63:0] info_field            // selected information
);

  logic [63:0] residue_ext;

  // residue widened with its sign, so negative stays two's complement
  assign residue_ext = {{(64-RES_W){residue[RES_W-1]}}, residue};

  // RQ20 residue or address
  assign info_field = ili ? residue_ext : lba;

endmodule : sda_info_select

// ==== design/sda_assembler.sv ====
// descriptor-format sense assembler, bytes 20 to 59
// Function
// RQ1 - command-specific descriptor at bytes 20-31
// RQ2 - command-specific type 01h, length 0Ah
// RQ3 - bytes 2-3 zero, 4-11 command info
// RQ4 - sense-key-specific descriptor at bytes 32-39
// RQ5 - sense-key-specific type 02h, length 06h
// RQ6 - bytes 4-6 copy fixed bytes 15-17
// RQ7 - replaceable unit descriptor at bytes 40-43
// RQ8 - replaceable unit type 03h, length 02h
// RQ9 - byte 3 holds replaceable part code
// RQ10 - block command descriptor at bytes 44-47
// RQ11 - block command type 05h, length 02h
// RQ12 - byte 3 only incorrect-length bit
// RQ13 - unit error descriptor at bytes 48-51
// RQ14 - unit error type 80h, length 02h
// RQ15 - bytes 2-3 hold unit error code
// RQ16 - physical record descriptor at bytes 52-59
// RQ17 - physical record type 81h, length 06h
// RQ18 - bytes 2-7 hold physical error record
// RQ19 - fixed order always, at most seven
// RQ20 - information field: residue or address
// RQ21 - reserved bytes and bits are zero
// assumes all inputs come from logic on the same clock
// and are held steady in the cycle that start is high
// the information descriptor bytes are built by other logic
`timescale 1ns/1ps
`include "sda_consts.svh"

module sda_assembler #(
  parameter int RES_W = 32
) (
  input wire logic clock,                    // 200 MHz system clock
  input wire logic reset,                    // async reset, active high
  input wire logic start,                    // take a snapshot and stream
  input wire logic out_ready,                // consumer takes out_data
  input wire logic [31:0] cmd_info,          // fixed-format bytes 8-11
  input wire logic [23:0] key_specific,      // fixed-format bytes 15-17
  input wire logic [7:0] replaceable_part_code, // fixed-format byte 14
  input wire logic ili,                      // incorrect-length bit
  input wire logic [31:0] vendor_info,       // fixed-format bytes 20-23
  input wire logic [47:0] phys_record,       // fixed-format bytes 24-29
  input wire logic [63:0] lba,               // block address
  input wire logic [RES_W-1:0] residue,      // signed length residue
  output logic busy,                         // stream in progress
  output logic out_valid,                    // out_data is offered
  output sda_pkg::sda_byte_t out_data,       // current buffer byte
  output sda_pkg::sda_ofs_t out_offset,      // buffer offset of out_data
  output sda_pkg::sda_desc_t out_desc,       // descriptor of out_data
  output logic out_first,                    // first byte of a descriptor
  output logic out_last,                     // byte 59, end of stream
  output logic done,                         // pulse after byte 59 taken
  output logic start_refused,                // pulse: start while busy
  output logic [2:0] desc_count,             // descriptors fully sent
  output logic [319:0] sense_image,          // bytes 20-59, byte 20 high
  output logic [63:0] info_field             // information field value
);
  import sda_pkg::*;

  // byte of a 40-byte image, index 0 is buffer byte 20
  function automatic sda_byte_t sda_pick(input logic [319:0] img,
                                         input sda_ofs_t idx);
    int pos;
    pos = (`SDA_IMG_BYTES - 1 - int'(idx)) * 8;
    return img[pos +: 8];
  endfunction : sda_pick

  // descriptor owning a buffer offset
  function automatic sda_desc_t sda_desc_of(input sda_ofs_t ofs);
    sda_desc_t d;
    d = sda_desc_per;
    if (ofs <= `SDA_CS_END) begin
      d = sda_desc_cmd;
    end else if (ofs <= `SDA_SKS_END) begin
      d = sda_desc_sks;
    end else if (ofs <= `SDA_FRU_END) begin
      d = sda_desc_fru;
    end else if (ofs <= `SDA_BLK_END) begin
      d = sda_desc_blk;
    end else if (ofs <= `SDA_UEC_END) begin
      d = sda_desc_uec;
    end
    return d;
  endfunction : sda_desc_of

  // true at the first byte of any descriptor
  function automatic logic sda_is_start(input sda_ofs_t ofs);
    return (ofs == `SDA_CS_OFS) || (ofs == `SDA_SKS_OFS) ||
           (ofs == `SDA_FRU_OFS) || (ofs == `SDA_BLK_OFS) ||
           (ofs == `SDA_UEC_OFS) || (ofs == `SDA_PER_OFS);
  endfunction : sda_is_start

  // true at the last byte of any descriptor
  function automatic logic sda_is_end(input sda_ofs_t ofs);
    return (ofs == `SDA_CS_END) || (ofs == `SDA_SKS_END) ||
           (ofs == `SDA_FRU_END) || (ofs == `SDA_BLK_END) ||
           (ofs == `SDA_UEC_END) || (ofs == `SDA_PER_END);
  endfunction : sda_is_end

  // descriptor header: type code then additional length
  function automatic logic [15:0] sda_head(input sda_byte_t code,
                                           input sda_byte_t len);
    return {code, len};
  endfunction : sda_head

  // registered state
  sda_state_t state_r;
  sda_state_t state_nxt;
  sda_ofs_t ofs_r;
  sda_ofs_t ofs_nxt;
  sda_byte_t data_r;
  sda_byte_t data_nxt;
  sda_desc_t desc_r;
  logic first_r;
  logic done_r;
  logic refused_r;
  logic [2:0] count_r;
  logic [2:0] count_nxt;
  logic [319:0] image_r;
  logic [63:0] info_r;

  // descriptor images, descriptor byte 0 on top
  logic [95:0] cmd_desc;
  logic [63:0] sks_desc;
  logic [31:0] fru_desc;
  logic [31:0] blk_desc;
  logic [31:0] uec_desc;
  logic [63:0] per_desc;
  logic [7:0] blk_flags;
  logic [15:0] unit_error_code;
  logic [319:0] image_w;
  logic [63:0] info_w;
  logic [15:0] cmd_head;
  logic [15:0] sks_head;
  logic [15:0] fru_head;
  logic [15:0] blk_head;
  logic [15:0] uec_head;
  logic [15:0] per_head;
  logic sks_valid;
  logic [22:0] sks_bits;

  // combinational terms
  logic idle;
  logic start_take;
  logic start_busy;
  logic accept;
  logic at_last;
  logic at_end;
  sda_ofs_t ofs_inc;
  sda_ofs_t idx_inc;

  // descriptor headers, type code then additional length
  // RQ2 command-specific type and length
  assign cmd_head = sda_head(`SDA_CS_TYPE, `SDA_CS_LEN);
  // RQ5 sense-key-specific type and length
  assign sks_head = sda_head(`SDA_SKS_TYPE, `SDA_SKS_LEN);
  // RQ8 replaceable unit type and length
  assign fru_head = sda_head(`SDA_FRU_TYPE, `SDA_FRU_LEN);
  // RQ11 block command type and length
  assign blk_head = sda_head(`SDA_BLK_TYPE, `SDA_BLK_LEN);
  // RQ14 unit error type and length
  assign uec_head = sda_head(`SDA_UEC_TYPE, `SDA_UEC_LEN);
  // RQ17 physical record type and length
  assign per_head = sda_head(`SDA_PER_TYPE, `SDA_PER_LEN);

  // command-specific descriptor, 12 bytes
  // RQ3 reserved then 8-byte info, fixed value in low four bytes
  // RQ21 reserved bytes zero
  assign cmd_desc = {cmd_head, 16'h0000,
                     32'h0000_0000, cmd_info};

  // sense-key-specific fields, valid flag on top
  // RQ6 valid flag and specific bits copied whole
  assign sks_valid = key_specific[23];
  assign sks_bits = key_specific[22:0];

  // sense-key-specific descriptor, 8 bytes
  // RQ21 bytes 2, 3 and 7 zero
  assign sks_desc = {sks_head, 16'h0000,
                     sks_valid, sks_bits, 8'h00};

  // replaceable unit descriptor, 4 bytes
  // RQ8 byte 2 zero
  // RQ9 part code in byte 3
  assign fru_desc = {fru_head, 8'h00, replaceable_part_code};

  // RQ12 only the incorrect-length bit set
  assign blk_flags = 8'(ili) << `SDA_ILI_BIT;

  // block command descriptor, 4 bytes
  // RQ11 byte 2 zero
  // RQ21 reserved bits of byte 3 zero
  assign blk_desc = {blk_head, 8'h00, blk_flags};

  // RQ15 code sits in the first two vendor bytes (20-21)
  assign unit_error_code = vendor_info[31:16];

  // unit error code descriptor, 4 bytes
  // RQ14 header then the code
  assign uec_desc = {uec_head, unit_error_code};

  // physical error record descriptor, 8 bytes
  // RQ18 six record bytes
  assign per_desc = {per_head, phys_record};

  // RQ19 fixed order regardless of content
  // RQ1 bytes 20-31 first
  // RQ4 bytes 32-39 next
  // RQ7 bytes 40-43
  // RQ10 bytes 44-47
  // RQ13 bytes 48-51
  // RQ16 bytes 52-59 last
  assign image_w = {cmd_desc,
                    sks_desc,
                    fru_desc,
                    blk_desc,
                    uec_desc,
                    per_desc};

  // RQ20 information field selection
  sda_info_select #(
    .RES_W(RES_W)
  ) u_info (
    .ili(ili),
    .lba(lba),
    .residue(residue),
    .info_field(info_w)
  );

  // handshake and sequencing terms
  assign idle = (state_r == sda_st_idle);
  assign start_take = start && idle;
  assign start_busy = start && !idle;
  // a byte leaves only while it is offered and taken
  assign accept = !idle && out_ready;
  assign at_last = (ofs_r == `SDA_BUF_LAST);
  assign at_end = sda_is_end(ofs_r);
  assign ofs_inc = ofs_r + 6'h01;
  // index of the next byte within the 40-byte image
  assign idx_inc = ofs_inc - `SDA_BUF_FIRST;

  // next state and offset
  // byte 20 comes from the live image, later bytes from the snapshot
  always_comb begin
    state_nxt = state_r;
    ofs_nxt = ofs_r;
    data_nxt = data_r;
    unique case (state_r)
      sda_st_idle: begin
        if (start_take) begin
          state_nxt = sda_st_send;
          ofs_nxt = `SDA_BUF_FIRST;
          data_nxt = sda_pick(image_w, 6'h00);
        end
      end
      sda_st_send: begin
        if (accept && at_last) begin
          state_nxt = sda_st_idle;
        end else if (accept) begin
          ofs_nxt = ofs_inc;
          data_nxt = sda_pick(image_r, idx_inc);
        end
      end
    endcase
  end

  // count of descriptors whose last byte was taken
  // RQ19 never above seven
  assign count_nxt = start_take ? `SDA_CNT_RST :
                     (accept && at_end && count_r < `SDA_DESC_MAX) ?
                     count_r + 3'h1 : count_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= sda_st_idle;
      ofs_r <= `SDA_OFS_RST;
      data_r <= `SDA_BYTE_RST;
    end else begin
      state_r <= state_nxt;
      ofs_r <= ofs_nxt;
      data_r <= data_nxt;
    end
  end

  // descriptor tag and first-byte mark follow the offset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      desc_r <= sda_desc_cmd;
      first_r <= 1'b0;
    end else begin
      desc_r <= sda_desc_of(ofs_nxt);
      first_r <= (state_nxt == sda_st_send) && sda_is_start(ofs_nxt);
    end
  end

  // snapshot of the image, held for the whole stream
  // inputs may move once streaming, so bytes after 20 all come from this one copy
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      image_r <= '0;
      info_r <= '0;
    end else if (start_take) begin
      image_r <= image_w;
      info_r <= info_w;
    end
  end

  // one-cycle status pulses and descriptor count
  // done rises as busy falls, so a new start may follow at once
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      count_r <= `SDA_CNT_RST;
    end else begin
      done_r <= accept && at_last;
      refused_r <= start_busy;
      count_r <= count_nxt;
    end
  end

  // stream handshake and byte lane
  assign busy = !idle;
  assign out_valid = !idle;
  assign out_data = data_r;
  assign out_offset = ofs_r;
  assign out_desc = desc_r;
  assign out_first = first_r;
  assign out_last = !idle && at_last;

  // status pulses and snapshot views
  assign done = done_r;
  assign start_refused = refused_r;
  assign desc_count = count_r;
  assign sense_image = image_r;
  assign info_field = info_r;

endmodule : sda_assembler

// ==== test/sda_assembler_props.sv ====
// stream and snapshot checks for the sense descriptor assembler
// assumes it is bound into sda_assembler and sees only its ports
`timescale 1ns/1ps
module sda_assembler_props #(
  parameter int RES_W = 32
) (
  input wire logic clock, // system clock
  input wire logic reset, // async reset
  input wire logic start, // stream request
  input wire logic out_ready, // consumer ready
  input wire logic ili, // incorrect-length bit
  input wire logic [63:0] lba, // block address
  input wire logic [RES_W-1:0] residue, // signed residue
  input wire logic busy, // streaming
  input wire logic out_valid, // byte offered
  input wire sda_pkg::sda_byte_t out_data, // offered byte
  input wire sda_pkg::sda_ofs_t out_offset, // its offset
  input wire logic [2:0] out_desc, // its descriptor
  input wire logic out_first, // descriptor start
  input wire logic out_last, // final byte
  input wire logic done, // stream over
  input wire logic start_refused, // start while busy
  input wire logic [2:0] desc_count, // descriptors sent
  input wire logic [319:0] sense_image, // bytes 20 to 59
  input wire logic [63:0] info_field // information value
);
  import sda_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_open_byte: assert property (start && !busy |=>
    out_valid && out_first && out_offset == 6'h14 && out_data == 8'h01)
    else $error("stream did not open at byte 20");
  a_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_offset))
    else $error("offered byte changed while stalled");
  a_offset_step: assert property (
    out_valid && out_ready && !out_last |=>
    out_valid && out_offset == $past(out_offset) + 6'h01)
    else $error("offset did not step by one");
  a_stream_end: assert property (
    out_valid && out_ready && out_offset == 6'h3b |->
    out_last ##1 (done && !busy && desc_count == 3'h6))
    else $error("stream end not marked");
  a_refuse_pulse: assert property (start && busy |=> start_refused)
    else $error("start while busy not refused");
  a_first_mark: assert property (out_valid |-> out_first ==
    (out_offset inside {6'h14, 6'h20, 6'h28, 6'h2c, 6'h30, 6'h34}))
    else $error("first-byte mark misplaced");
  a_info_sel: assert property (start && !busy |=> info_field ==
    ($past(ili) ? {{(64-RES_W){$past(residue[RES_W-1])}}, $past(residue)}
    : $past(lba)))
    else $error("information field wrong");
  a_image_byte: assert property (out_valid |->
    out_data == sense_image[(6'h3b - out_offset) * 8 +: 8])
    else $error("streamed byte differs from image");
  a_desc_tag: assert property (out_valid |->
    ((out_desc == sda_desc_cmd) == (out_offset inside {[6'h14:6'h1f]})) &&
    ((out_desc == sda_desc_sks) == (out_offset inside {[6'h20:6'h27]})) &&
    ((out_desc == sda_desc_fru) == (out_offset inside {[6'h28:6'h2b]})) &&
    ((out_desc == sda_desc_blk) == (out_offset inside {[6'h2c:6'h2f]})) &&
    ((out_desc == sda_desc_uec) == (out_offset inside {[6'h30:6'h33]})) &&
    ((out_desc == sda_desc_per) == (out_offset inside {[6'h34:6'h3b]})))
    else $error("descriptor tag does not match offset");
  a_type_codes: assert property (busy |->
    {sense_image[319:304], sense_image[223:208], sense_image[159:144],
    sense_image[127:112], sense_image[95:80], sense_image[63:48]} ==
    96'h010a_0206_0302_0502_8002_8106)
    else $error("descriptor header codes wrong");
endmodule : sda_assembler_props

bind sda_assembler sda_assembler_props #(.RES_W(RES_W)) props_i (
  .clock, .reset, .start, .out_ready, .ili, .lba, .residue, .busy,
  .out_valid, .out_data, .out_offset, .out_desc, .out_first, .out_last,
  .done,
  .start_refused, .desc_count, .sense_image, .info_field);

// ==== test/sda_consumer.sv ====
// far-side consumer of the descriptor byte stream
// assumes bytes are taken on out_valid and out_ready together
`timescale 1ns/1ps
module sda_consumer (
  input wire logic clock, // system clock
  input wire logic reset, // async reset
  input wire logic slow, // stall every other cycle
  input wire logic out_valid, // byte offered
  input wire sda_pkg::sda_ofs_t out_offset, // its offset
  input wire sda_pkg::sda_byte_t out_data, // the byte
  output logic out_ready // byte taken
);
  import sda_pkg::*;
  sda_byte_t got [0:63];
  int taken;
  logic phase_r;
  assign out_ready = !slow || phase_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_r <= 1'b0;
      taken <= 0;
    end else begin
      phase_r <= !phase_r;
      if (out_valid && out_ready) begin
        got[out_offset] <= out_data;
        taken <= taken + 1;
      end
    end
  end
endmodule : sda_consumer

// ==== test/sda_assembler_test.sv ====
// self-checking bench for the sense descriptor assembler
// assumes sda_consumer takes the stream on the far side
`timescale 1ns/1ps
module sda_assembler_test;
  import sda_pkg::*;
  logic clock, reset, start, slow, out_ready, busy, out_valid, out_first;
  logic out_last, done, start_refused, ili;
  logic [31:0] cmd_info, vendor_info, residue;
  logic [23:0] key_specific;
  logic [7:0] replaceable_part_code;
  logic [47:0] phys_record;
  logic [63:0] lba, info_field, exp_info;
  logic [2:0] desc_count;
  logic [319:0] sense_image, exp_img;
  sda_byte_t out_data;
  sda_ofs_t out_offset;
  int err_count, comparisons, t0;

  sda_assembler #(.RES_W(32)) uut (.clock, .reset, .start, .out_ready,
    .cmd_info, .key_specific, .replaceable_part_code, .ili, .vendor_info,
    .phys_record, .lba, .residue, .busy, .out_valid, .out_data,
    .out_offset, .out_desc(), .out_first, .out_last, .done,
    .start_refused, .desc_count, .sense_image, .info_field);
  sda_consumer cons (.clock, .reset, .slow, .out_valid, .out_offset,
    .out_data, .out_ready);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [63:0] exp, got);
    comparisons++;
    if (exp !== got) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results;
    $display("compared %0d, mismatched %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // drive the fixed-format fields and work out the expected image
  task automatic load(input logic [31:0] c, input logic [23:0] k,
      input logic [7:0] p, input logic i, input logic [31:0] v,
      input logic [47:0] ph, input logic [63:0] l, input logic [31:0] r);
    cmd_info <= c;
    key_specific <= k;
    replaceable_part_code <= p;
    ili <= i;
    vendor_info <= v;
    phys_record <= ph;
    lba <= l;
    residue <= r;
    exp_img = {16'h010a, 48'h0, c, 16'h0206, 16'h0, k, 8'h00, 16'h0302,
      8'h00, p, 16'h0502, 8'h00, 2'b00, i, 5'h00, 16'h8002, v[31:16],
      16'h8106, ph};
    exp_info = i ? {{32{r[31]}}, r} : l;
  endtask : load

  // one stream; poke retries start and scrambles inputs while busy
  task automatic stream(input string name, input logic s, input logic poke);
    int n;
    slow <= s;
    start <= 1'b1;
    t0 = cons.taken;
    @(posedge clock);
    start <= 1'b0;
    if (poke) begin
      @(posedge clock);
      start <= 1'b1;
      cmd_info <= ~cmd_info;
      phys_record <= ~phys_record;
      ili <= ~ili;
      lba <= ~lba;
      @(posedge clock);
      start <= 1'b0;
      @(posedge clock);
      check("start_refused", 64'h1, start_refused);
    end
    for (n = 0; n < 200 && !done; n++)
      @(posedge clock);
    if (!done) begin
      err_count++;
      results;
    end
    check("desc_count", 64'h6, desc_count);
    check("taken", 64'h28, 64'(cons.taken - t0));
    for (n = 20; n < 60; n++)
      check($sformatf("byte %0d", n),
        exp_img[(59-n)*8 +: 8], cons.got[n]);
    check("info_field", exp_info, info_field);
    $display("test %s finished", name);
  endtask : stream

  // outputs quiet at the first edge after release
  task automatic test_reset;
    @(posedge clock);
    check("reset state", 64'h0,
      {done, out_valid, desc_count, |sense_image});
    $display("test reset finished");
  endtask : test_reset

  // mixed field values, consumer always ready
  task automatic test_plain;
    load(32'h11223344, 24'h8a5b6c, 8'h7e, 1'b0, 32'hf101abcd,
      48'h010203040506, 64'h0123456789abcdef, 32'h0);
    stream("plain", 1'b0, 1'b0);
  endtask : test_plain

  // all ones must leave reserved bytes zero, negative residue
  task automatic test_stalled;
    load('1, '1, '1, 1'b1, '1, '1, 64'h0, 32'hfffffff0);
    stream("all ones stalled", 1'b1, 1'b0);
  endtask : test_stalled

  // start while busy is refused and the snapshot holds
  task automatic test_refused;
    load(32'h89abcdef, 24'h00ff00, 8'h00, 1'b1, 32'h12345678,
      48'ha5a5a5a5a5a5, 64'h5, 32'h40);
    stream("refused start", 1'b1, 1'b1);
  endtask : test_refused

  initial begin
    err_count = 0;
    comparisons = 0;
    reset = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    test_reset;
    test_plain;
    test_stalled;
    test_refused;
    results;
  end
endmodule : sda_assembler_test
